// file: crxpc_map.svh
// Purpose: Register offsets, config keys, defaults and timing for the receiver control block
// Assumes: APB byte addresses, 250 MHz system clock
// Notes: Definitions only
`ifndef CRXPC_MAP_SVH
`define CRXPC_MAP_SVH
// Register byte offsets
`define CRXPC_A_CMD 8'h00
`define CRXPC_A_VAL_LO 8'h04
`define CRXPC_A_VAL_HI 8'h08
`define CRXPC_A_RESP 8'h0c
`define CRXPC_A_RD_LO 8'h10
`define CRXPC_A_RD_HI 8'h14
`define CRXPC_A_STATUS 8'h18
// Command word fields and operation codes
`define CRXPC_CMD_OP 2:0
`define CRXPC_CMD_KEY 15:8
`define CRXPC_CMD_PORT 17:16
`define CRXPC_OP_SET 3'h1
`define CRXPC_OP_GET 3'h2
`define CRXPC_OP_DEL 3'h3
`define CRXPC_OP_PMREQ 3'h4
`define CRXPC_OP_POLL 3'h5
// Configuration keys; per-port groups use the low two key bits as port
`define CRXPC_K_FREQ 8'h01
`define CRXPC_K_WINDOW 8'h02
`define CRXPC_K_SVCEN 8'h03
`define CRXPC_K_SVCID 8'h04
`define CRXPC_K_RATE 8'h05
`define CRXPC_K_DSCEN 8'h06
`define CRXPC_K_SEED 8'h07
`define CRXPC_K_UWTHR 8'h08
`define CRXPC_K_PRSEN 8'h09
`define CRXPC_K_SYNC 8'h0a
`define CRXPC_K_BAUD 8'h20
`define CRXPC_G_OUTPROT 6'h04
`define CRXPC_G_PERRATE 6'h05
`define CRXPC_G_INFOEN 6'h06
`define CRXPC_G_INPROT 6'h07
// Defaults after reset
`define CRXPC_D_FREQ 32'h5bc7ac94
`define CRXPC_D_WINDOW 16'h0898
`define CRXPC_D_SVCEN 1'h1
`define CRXPC_D_SVCID 16'hc685
`define CRXPC_D_RATE 16'h0960
`define CRXPC_D_DSCEN 1'h1
`define CRXPC_D_SEED 16'h5c08
`define CRXPC_D_UWTHR 8'h04
`define CRXPC_D_PRSEN 1'h0
`define CRXPC_D_SYNC 64'he15ae893e15ae893
`define CRXPC_D_BAUD 32'h00002580
`define CRXPC_D_PROT 1'h1
`define CRXPC_D_PERRATE 8'h00
`define CRXPC_D_INFOEN 1'h0
// Legal ranges
`define CRXPC_FREQ_MIN 32'h5ae5a740
`define CRXPC_FREQ_MAX 32'h5cec73c0
`define CRXPC_RATE_MIN 16'h0258
`define CRXPC_RATE_MAX 16'h12c0
// Timing
`define CRXPC_TIME_MS_NS 1000000
`define CRXPC_CLK_PERIOD_NS 4
`define CRXPC_MS_CYCLES (`CRXPC_TIME_MS_NS / `CRXPC_CLK_PERIOD_NS)
`endif

// file: crxpc_pkg.sv
// Purpose: Shared types of the receiver control block
// Assumes: Nothing beyond the map header
// Notes: Numbers live in crxpc_map.svh
`default_nettype none
package crxpc_pkg;
  // Receiver activity states
  typedef enum logic [1:0] {ST_BOOT, ST_ACQ, ST_TRACK, ST_INACTIVE} crxpc_state_e;
  typedef logic [63:0] crxpc_value_t;
  typedef logic [7:0] crxpc_key_t;
endpackage : crxpc_pkg
`default_nettype wire

// file: crxpc_top.sv
// Purpose: Configuration database, message gating and power state control
// Assumes: Pins synchronous to clk_sys except the wake pins, which are resynchronised
// Notes: APB slave, one wait state on every access
//
// Overview of operation
// [R01] Boot: defaults, then flash overlay, then runtime
// [R02] Store holds key/value items grouped by key
// [R03] Each set/get/delete gets one ack or nak
// [R04] Correction channel defaults loaded at reset
// [R05] Host keeps centre frequency within legal band
// [R06] Host keeps bit rate within 600 to 4800
// [R07] Serial port defaults 9600 8N1, binary on
// [R08] Other ports default like the serial port
// [R09] Boot text emitted at power-up
// [R10] Per-port rate: zero off, N events each
// [R11] Version report only on poll
// [R12] Info text gated by per-port enable
// [R13] Nothing out until protocol output enabled; boot text is not gated by it
// [R14] Frame message per matching received frame
// [R15] Host checks frame validity via quality fields
// [R16] Power request: inactive for duration or wake
// [R17] Wake on pin edges and reset rise
// [R18] Wake always leads into acquisition
// [R19] Wake ignored in acquisition or tracking
// [R20] Host holds wake level over 1 ms
// [R21] Wake pins synchronised before edge detection
// [R22] Out-of-range set refused, item kept
//
// The placing of the registers and the APB interface to the registers were left to the implementer.
`include "crxpc_map.svh"
`timescale 1ns/1ps
`default_nettype none
module crxpc_top #(
  parameter int NPORT = 4,
  parameter int MS_CYCLES = `CRXPC_MS_CYCLES
) (
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic flashValid,
  input wire crxpc_pkg::crxpc_key_t flashKey,
  input wire crxpc_pkg::crxpc_value_t flashValue,
  input wire logic flashDone,
  input wire logic periodicEvent,
  input wire logic infoRequest,
  input wire logic frameRx,
  input wire logic [15:0] frameServiceId,
  input wire logic lockAcquired,
  input wire logic extWakePin,
  input wire logic serialRxPin,
  input wire logic resetPinN,
  output logic [NPORT-1:0] periodicEmit,
  output logic [NPORT-1:0] frameEmit,
  output logic [NPORT-1:0] versionEmit,
  output logic [NPORT-1:0] infoEmit,
  output logic [NPORT-1:0] bootTextEmit,
  output crxpc_pkg::crxpc_state_e rxState,
  output logic [31:0] channelCentreFreq,
  output logic [15:0] freqSearchWindow,
  output logic serviceFilterEnable,
  output logic [15:0] serviceIdentifier,
  output logic [15:0] channelBitRate,
  output logic descramblerEnable,
  output logic [15:0] descramblerSeed,
  output logic [7:0] syncWordErrorThreshold,
  output logic prescramblingEnable,
  output logic [63:0] frameSyncWord,
  output logic [31:0] serialBaud
);
  import crxpc_pkg::*;

  logic [NPORT-1:0] outProtEn_r, inProtEn_r, infoEn_r;
  logic [7:0] perRate_r [NPORT];
  logic [7:0] perCnt_r [NPORT];
  logic [31:0] valLo_r, valHi_r, rdLo_r, rdHi_r;
  logic respValid_r, respAck_r;
  logic [7:0] respSeq_r;
  logic [31:0] sleepMs_r, msCnt_r;
  logic [2:0] extSync_r, rxSync_r, rstSync_r;

  // Item is a known key of the database
  function automatic logic isKnown(input crxpc_key_t k);
    return (k >= `CRXPC_K_FREQ && k <= `CRXPC_K_SYNC) || k == `CRXPC_K_BAUD
        || (k[7:2] >= `CRXPC_G_OUTPROT && k[7:2] <= `CRXPC_G_INPROT);
  endfunction : isKnown

  // Value fits the legal range of the item
  function automatic logic inRange(input crxpc_key_t k, input crxpc_value_t v);
    case (k)
      `CRXPC_K_FREQ: return v[63:32] == 32'h0 && v[31:0] >= `CRXPC_FREQ_MIN
          && v[31:0] <= `CRXPC_FREQ_MAX; // R05 R22
      `CRXPC_K_RATE: return v[63:16] == 48'h0 && v[15:0] >= `CRXPC_RATE_MIN
          && v[15:0] <= `CRXPC_RATE_MAX; // R06 R22
      `CRXPC_K_SVCEN, `CRXPC_K_DSCEN, `CRXPC_K_PRSEN: return v[63:1] == 63'h0;
      `CRXPC_K_WINDOW, `CRXPC_K_SVCID, `CRXPC_K_SEED: return v[63:16] == 48'h0;
      `CRXPC_K_UWTHR: return v[63:8] == 56'h0;
      `CRXPC_K_SYNC: return 1'b1;
      `CRXPC_K_BAUD: return v[63:32] == 32'h0 && v[31:0] != 32'h0;
      default: return k[7:2] == `CRXPC_G_PERRATE ? v[63:8] == 56'h0 : v[63:1] == 63'h0;
    endcase
  endfunction : inRange

  // Factory value of an item, used by delete; reset loads the same defaults directly
  function automatic crxpc_value_t defaultOf(input crxpc_key_t k);
    case (k)
      `CRXPC_K_FREQ: return {32'h0, `CRXPC_D_FREQ};
      `CRXPC_K_WINDOW: return {48'h0, `CRXPC_D_WINDOW};
      `CRXPC_K_SVCEN: return {63'h0, `CRXPC_D_SVCEN};
      `CRXPC_K_SVCID: return {48'h0, `CRXPC_D_SVCID};
      `CRXPC_K_RATE: return {48'h0, `CRXPC_D_RATE};
      `CRXPC_K_DSCEN: return {63'h0, `CRXPC_D_DSCEN};
      `CRXPC_K_SEED: return {48'h0, `CRXPC_D_SEED};
      `CRXPC_K_UWTHR: return {56'h0, `CRXPC_D_UWTHR};
      `CRXPC_K_PRSEN: return {63'h0, `CRXPC_D_PRSEN};
      `CRXPC_K_SYNC: return `CRXPC_D_SYNC;
      `CRXPC_K_BAUD: return {32'h0, `CRXPC_D_BAUD};
      default: return k[7:2] == `CRXPC_G_PERRATE ? {56'h0, `CRXPC_D_PERRATE}
          : k[7:2] == `CRXPC_G_INFOEN ? {63'h0, `CRXPC_D_INFOEN} : {63'h0, `CRXPC_D_PROT};
    endcase
  endfunction : defaultOf

  // Current value of an item for the get command
  function automatic crxpc_value_t readKey(input crxpc_key_t k);
    case (k)
      `CRXPC_K_FREQ: return {32'h0, channelCentreFreq};
      `CRXPC_K_WINDOW: return {48'h0, freqSearchWindow};
      `CRXPC_K_SVCEN: return {63'h0, serviceFilterEnable};
      `CRXPC_K_SVCID: return {48'h0, serviceIdentifier};
      `CRXPC_K_RATE: return {48'h0, channelBitRate};
      `CRXPC_K_DSCEN: return {63'h0, descramblerEnable};
      `CRXPC_K_SEED: return {48'h0, descramblerSeed};
      `CRXPC_K_UWTHR: return {56'h0, syncWordErrorThreshold};
      `CRXPC_K_PRSEN: return {63'h0, prescramblingEnable};
      `CRXPC_K_SYNC: return frameSyncWord;
      `CRXPC_K_BAUD: return {32'h0, serialBaud};
      default: case (k[7:2])
        `CRXPC_G_OUTPROT: return {63'h0, outProtEn_r[k[1:0]]};
        `CRXPC_G_PERRATE: return {56'h0, perRate_r[k[1:0]]};
        `CRXPC_G_INFOEN: return {63'h0, infoEn_r[k[1:0]]};
        default: return {63'h0, inProtEn_r[k[1:0]]};
      endcase
    endcase
  endfunction : readKey

  // APB decode; the answer comes one cycle into the access phase
  logic apbAcc, wrStb, cmdFire, mapped;
  logic [2:0] cmdOp;
  crxpc_key_t cmdKey, wrKey;
  crxpc_value_t cmdVal, wrVal;
  logic cmdOk, wrGo;
  assign apbAcc = psel & penable;
  assign wrStb = apbAcc & pready & pwrite;
  assign mapped = paddr <= `CRXPC_A_STATUS && paddr[1:0] == 2'h0;
  assign cmdFire = wrStb && paddr == `CRXPC_A_CMD;
  assign cmdOp = pwdata[`CRXPC_CMD_OP];
  assign cmdKey = pwdata[`CRXPC_CMD_KEY];
  assign cmdVal = {valHi_r, valLo_r};
  assign cmdOk = isKnown(cmdKey) && (cmdOp != `CRXPC_OP_SET || inRange(cmdKey, cmdVal)); // R22

  // One writer into the store: flash overlay at boot, commands at run time
  always_comb begin
    wrGo = 1'b0;
    wrKey = cmdKey;
    wrVal = cmdVal;
    if (rxState == ST_BOOT) begin
      wrGo = flashValid && isKnown(flashKey) && inRange(flashKey, flashValue); // R01
      wrKey = flashKey;
      wrVal = flashValue;
    end else if (cmdFire && cmdOk) begin
      wrGo = cmdOp == `CRXPC_OP_SET || cmdOp == `CRXPC_OP_DEL;
      wrVal = cmdOp == `CRXPC_OP_DEL ? defaultOf(cmdKey) : cmdVal;
    end
  end

  // APB handshake and read data
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0;
    end else begin
      pready <= apbAcc & ~pready;
      pslverr <= apbAcc & ~pready & ~mapped;
      prdata <= 32'h0;
      if (apbAcc && !pready && !pwrite) begin
        case (paddr)
          `CRXPC_A_VAL_LO: prdata <= valLo_r;
          `CRXPC_A_VAL_HI: prdata <= valHi_r;
          `CRXPC_A_RESP: prdata <= {22'h0, respSeq_r, respAck_r, respValid_r};
          `CRXPC_A_RD_LO: prdata <= rdLo_r;
          `CRXPC_A_RD_HI: prdata <= rdHi_r;
          `CRXPC_A_STATUS: prdata <= {30'h0, rxState};
          default: prdata <= 32'h0;
        endcase
      end
    end
  end

  // Value staging registers
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      valLo_r <= 32'h0;
      valHi_r <= 32'h0;
    end else if (wrStb && paddr == `CRXPC_A_VAL_LO) begin
      valLo_r <= pwdata;
    end else if (wrStb && paddr == `CRXPC_A_VAL_HI) begin
      valHi_r <= pwdata;
    end
  end

  // Response: a new set, get or delete command sets valid, beating a read that clears it
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      respValid_r <= 1'b0;
      respAck_r <= 1'b0;
      respSeq_r <= 8'h0;
      rdLo_r <= 32'h0;
      rdHi_r <= 32'h0;
    end else if (cmdFire && cmdOp >= `CRXPC_OP_SET && cmdOp <= `CRXPC_OP_DEL) begin
      respValid_r <= 1'b1; // R03
      respAck_r <= cmdOk; // R03
      respSeq_r <= respSeq_r + 8'h1;
      if (cmdOp == `CRXPC_OP_GET && cmdOk) begin
        {rdHi_r, rdLo_r} <= readKey(cmdKey);
      end
    end else if (apbAcc && pready && !pwrite && paddr == `CRXPC_A_RESP) begin
      respValid_r <= 1'b0;
    end
  end

  // Scalar items of the store
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      channelCentreFreq <= `CRXPC_D_FREQ; // R04
      freqSearchWindow <= `CRXPC_D_WINDOW; // R04
      serviceFilterEnable <= `CRXPC_D_SVCEN;
      serviceIdentifier <= `CRXPC_D_SVCID;
      channelBitRate <= `CRXPC_D_RATE;
      descramblerEnable <= `CRXPC_D_DSCEN;
      descramblerSeed <= `CRXPC_D_SEED;
      syncWordErrorThreshold <= `CRXPC_D_UWTHR;
      prescramblingEnable <= `CRXPC_D_PRSEN;
      frameSyncWord <= `CRXPC_D_SYNC;
      serialBaud <= `CRXPC_D_BAUD; // R07
    end else if (wrGo) begin
      case (wrKey) // R02
        `CRXPC_K_FREQ: channelCentreFreq <= wrVal[31:0];
        `CRXPC_K_WINDOW: freqSearchWindow <= wrVal[15:0];
        `CRXPC_K_SVCEN: serviceFilterEnable <= wrVal[0];
        `CRXPC_K_SVCID: serviceIdentifier <= wrVal[15:0];
        `CRXPC_K_RATE: channelBitRate <= wrVal[15:0];
        `CRXPC_K_DSCEN: descramblerEnable <= wrVal[0];
        `CRXPC_K_SEED: descramblerSeed <= wrVal[15:0];
        `CRXPC_K_UWTHR: syncWordErrorThreshold <= wrVal[7:0];
        `CRXPC_K_PRSEN: prescramblingEnable <= wrVal[0];
        `CRXPC_K_SYNC: frameSyncWord <= wrVal;
        `CRXPC_K_BAUD: serialBaud <= wrVal[31:0];
        default: ;
      endcase
    end
  end

  // Per-port items; every port starts like the serial port
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      for (int i = 0; i < NPORT; i++) begin
        outProtEn_r[i] <= `CRXPC_D_PROT; // R07 R08
        inProtEn_r[i] <= `CRXPC_D_PROT; // R08
        infoEn_r[i] <= `CRXPC_D_INFOEN;
        perRate_r[i] <= `CRXPC_D_PERRATE;
      end
    end else if (wrGo) begin
      case (wrKey[7:2])
        `CRXPC_G_OUTPROT: outProtEn_r[wrKey[1:0]] <= wrVal[0];
        `CRXPC_G_PERRATE: perRate_r[wrKey[1:0]] <= wrVal[7:0];
        `CRXPC_G_INFOEN: infoEn_r[wrKey[1:0]] <= wrVal[0];
        `CRXPC_G_INPROT: inProtEn_r[wrKey[1:0]] <= wrVal[0];
        default: ;
      endcase
    end
  end

  // Output gating per port; protocol enable masks everything binary
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      periodicEmit <= '0;
      frameEmit <= '0;
      versionEmit <= '0;
      infoEmit <= '0;
      bootTextEmit <= '0;
      for (int i = 0; i < NPORT; i++) perCnt_r[i] <= 8'h0;
    end else begin
      for (int i = 0; i < NPORT; i++) begin
        periodicEmit[i] <= 1'b0;
        if (periodicEvent && perRate_r[i] != 8'h0) begin // R10
          if (perCnt_r[i] + 8'h1 >= perRate_r[i]) begin
            perCnt_r[i] <= 8'h0;
            periodicEmit[i] <= outProtEn_r[i]; // R13
          end else begin
            perCnt_r[i] <= perCnt_r[i] + 8'h1;
          end
        end
        frameEmit[i] <= frameRx && outProtEn_r[i] // R14 R13
            && (!serviceFilterEnable || frameServiceId == serviceIdentifier);
        versionEmit[i] <= cmdFire && cmdOp == `CRXPC_OP_POLL
            && pwdata[`CRXPC_CMD_PORT] == 2'(i) && outProtEn_r[i]; // R11 R13
        infoEmit[i] <= infoRequest && infoEn_r[i] && outProtEn_r[i]; // R12 R13
        bootTextEmit[i] <= rxState == ST_BOOT && flashDone; // R09
      end
    end
  end

  // Wake pins: two-stage synchroniser, third stage for edges
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      extSync_r <= 3'h0;
      rxSync_r <= 3'h7;
      rstSync_r <= 3'h7;
    end else begin
      extSync_r <= {extSync_r[1:0], extWakePin}; // R21
      rxSync_r <= {rxSync_r[1:0], serialRxPin}; // R21
      rstSync_r <= {rstSync_r[1:0], resetPinN}; // R21
    end
  end

  logic wakeEvt, msTick;
  assign wakeEvt = (extSync_r[2] ^ extSync_r[1]) | (rxSync_r[2] ^ rxSync_r[1]) // R17
      | (~rstSync_r[2] & rstSync_r[1]); // R17
  assign msTick = msCnt_r == 32'(MS_CYCLES - 1);

  // Millisecond enable; restarts on a request so the first step is a whole ms
  always_ff @(posedge clk_sys) begin
    if (srst || msTick || (cmdFire && cmdOp == `CRXPC_OP_PMREQ)) begin // R16
      msCnt_r <= 32'h0;
    end else begin
      msCnt_r <= msCnt_r + 32'h1;
    end
  end

  // Receiver activity; a zero duration sleeps until a wake event
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      rxState <= ST_BOOT;
      sleepMs_r <= 32'h0;
    end else begin
      case (rxState)
        ST_BOOT: if (flashDone) rxState <= ST_ACQ; // R01
        ST_ACQ, ST_TRACK: begin
          if (cmdFire && cmdOp == `CRXPC_OP_PMREQ) begin
            rxState <= ST_INACTIVE; // R16
            sleepMs_r <= valLo_r;
          end else begin
            rxState <= lockAcquired ? ST_TRACK : ST_ACQ; // R19
          end
        end
        ST_INACTIVE: begin
          if (wakeEvt || (msTick && sleepMs_r == 32'h1)) begin
            rxState <= ST_ACQ; // R16 R18
          end else if (msTick && sleepMs_r != 32'h0) begin
            sleepMs_r <= sleepMs_r - 32'h1;
          end
        end
        default: rxState <= ST_BOOT;
      endcase
    end
  end
endmodule : crxpc_top
`default_nettype wire

// file: crxpc_checker_properties.sv
// Purpose: Port-level properties of the receiver control block
// Assumes: Sees only the top module ports, one clock domain
// Notes: Bound to every crxpc_top instance at the foot of this file
`include "crxpc_map.svh"
`timescale 1ns/1ps
`default_nettype none
module crxpc_checker #(
  parameter int NPORT = 4
) (
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic flashDone,
  input wire logic infoRequest,
  input wire logic frameRx,
  input wire logic extWakePin,
  input wire logic serialRxPin,
  input wire logic resetPinN,
  input wire logic [NPORT-1:0] frameEmit,
  input wire logic [NPORT-1:0] versionEmit,
  input wire logic [NPORT-1:0] infoEmit,
  input wire logic [NPORT-1:0] bootTextEmit,
  input wire crxpc_pkg::crxpc_state_e rxState,
  input wire logic [31:0] channelCentreFreq,
  input wire logic [15:0] channelBitRate,
  input wire logic [63:0] frameSyncWord,
  input wire logic [31:0] serialBaud
);
  import crxpc_pkg::*;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (srst);
  // Values seen at the first edge after reset release
  cfg_default_a: assert property ($fell(srst) |-> channelCentreFreq == `CRXPC_D_FREQ &&
    channelBitRate == `CRXPC_D_RATE && frameSyncWord == `CRXPC_D_SYNC)
    else $error("channel defaults");
  port_default_a: assert property ($fell(srst) |-> serialBaud == `CRXPC_D_BAUD)
    else $error("baud default");
  // Each boot text, version, info and frame emit must trace back to its cause one cycle earlier
  boot_text_a: assert property (|bootTextEmit |-> &bootTextEmit && $past(flashDone) &&
    $past(rxState) == ST_BOOT)
    else $error("stray boot text");
  version_poll_a: assert property (|versionEmit |-> $onehot(versionEmit) &&
    $past(psel && penable && pready && pwrite && paddr == `CRXPC_A_CMD &&
    pwdata[2:0] == `CRXPC_OP_POLL))
    else $error("stray version");
  info_gate_a: assert property (|infoEmit |-> $past(infoRequest))
    else $error("stray info");
  frame_cause_a: assert property (|frameEmit |-> $past(frameRx))
    else $error("stray frame");
  // Wake pins: synchroniser delay bounds the reaction
  wake_edge_a: assert property (rxState == ST_INACTIVE &&
    ($changed(extWakePin) || $changed(serialRxPin)) |-> ##[1:4] rxState == ST_ACQ)
    else $error("pin edge did not wake");
  wake_reset_a: assert property (rxState == ST_INACTIVE && $rose(resetPinN)
    |-> ##[1:4] rxState == ST_ACQ)
    else $error("reset pin rise did not wake");
  wake_acq_a: assert property (!$past(srst) && $past(rxState) == ST_INACTIVE &&
    rxState != ST_INACTIVE |-> rxState == ST_ACQ)
    else $error("wake not to acquisition");
  // Only a bus write may send an active receiver inactive
  stay_active_a: assert property ((rxState == ST_ACQ || rxState == ST_TRACK) &&
    !(psel && pwrite) && !$past(psel && pwrite) |=> rxState != ST_INACTIVE)
    else $error("unrequested sleep");
endmodule : crxpc_checker
bind crxpc_top crxpc_checker #(.NPORT(NPORT)) chk_u (.*);
`default_nettype wire

// file: crxpc_host_model.sv
// Purpose: Host side: bus requester and wake pin driver
// Assumes: Called right after a rising clock edge
// Notes: Waits on pready without limit; the bench watchdog ends hangs
`timescale 1ns/1ps
`default_nettype none
module crxpc_host_model #(
  parameter int HOLD = 12
) (
  input wire logic clk_sys,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [7:0] paddr,
  output logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  output logic extWakePin,
  output logic serialRxPin,
  output logic resetPinN
);
  // Idle bus, serial line idle high, reset pin released
  initial begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {extWakePin, serialRxPin, resetPinN} = 3'b011;
  end
  // One transfer; values sent are the caller's, range kept by caller
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
      output logic [31:0] rd, output logic err);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do @(posedge clk_sys); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    // Released lines change so a stale request cannot look valid
    psel <= 1'b0;
    penable <= 1'b0;
    paddr <= ~a;
    pwdata <= ~d;
    @(posedge clk_sys);
  endtask : xfer
  // Flip one wake pin and hold the new level HOLD cycles
  task automatic toggle(input int p);
    case (p)
      0: extWakePin <= ~extWakePin;
      1: serialRxPin <= ~serialRxPin;
      default: resetPinN <= ~resetPinN;
    endcase
    repeat (HOLD) @(posedge clk_sys);
  endtask : toggle
endmodule : crxpc_host_model
`default_nettype wire

// file: crxpc_top_tb.sv
// Purpose: Self-checking bench of the receiver control block
// Assumes: Millisecond count shortened to 10 cycles
// Notes: Emit counters are cleared at reset and before the output scenario
`include "crxpc_map.svh"
`timescale 1ns/1ps
`default_nettype none
module crxpc_top_tb;
  import crxpc_pkg::*;
  localparam int MS = 10;
  logic clk_sys, srst, psel, penable, pwrite, pready, pslverr, clrCnt;
  logic [7:0] paddr, syncWordErrorThreshold;
  logic [31:0] pwdata, prdata, channelCentreFreq, serialBaud;
  logic flashValid, flashDone, periodicEvent, infoRequest, frameRx, lockAcquired;
  logic extWakePin, serialRxPin, resetPinN;
  logic serviceFilterEnable, descramblerEnable, prescramblingEnable;
  crxpc_key_t flashKey;
  crxpc_value_t flashValue;
  logic [15:0] frameServiceId, freqSearchWindow, serviceIdentifier;
  logic [15:0] channelBitRate, descramblerSeed;
  logic [3:0] periodicEmit, frameEmit, versionEmit, infoEmit, bootTextEmit;
  logic [3:0] emitVec[5];
  crxpc_state_e rxState;
  logic [63:0] frameSyncWord;
  int fail_count, comparisons, expSeq;
  logic [4:0][3:0][3:0] cnt;
  crxpc_top #(.NPORT(4), .MS_CYCLES(MS)) dut_u (.*);
  crxpc_host_model #(.HOLD(12)) hostU (.*);
  // Emit counters: 0 periodic, 1 frame, 2 version, 3 info, 4 boot text
  assign emitVec = '{periodicEmit, frameEmit, versionEmit, infoEmit, bootTextEmit};
  always @(posedge clk_sys) begin
    foreach (cnt[k, i]) cnt[k][i] <= clrCnt ? 4'h0 : cnt[k][i] + 4'(emitVec[k][i]);
  end
  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end
  task automatic check(input logic ok, input string what);
    comparisons++;
    if (ok !== 1'b1) begin
      fail_count++;
      $display("[FAIL] %0t %s", $time, what);
    end
  endtask : check
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    hostU.xfer(1'b1, a, d, r, e);
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] r, output logic e);
    hostU.xfer(1'b0, a, 32'h0, r, e);
  endtask : rd
  // Value first, then the command; the answer word carries seq, ack, valid
  task automatic cmd(input logic [2:0] op, input logic [7:0] key, input logic [63:0] v,
      input logic ack);
    logic [31:0] r;
    logic e;
    wr(`CRXPC_A_VAL_LO, v[31:0]);
    wr(`CRXPC_A_VAL_HI, v[63:32]);
    wr(`CRXPC_A_CMD, {16'h0, key, 5'h0, op});
    expSeq++;
    rd(`CRXPC_A_RESP, r, e);
    check(r[9:0] === {expSeq[7:0], ack, 1'b1}, "response word");
  endtask : cmd
  task automatic t_boot;
    check(serviceIdentifier === 16'd50821 && channelCentreFreq === 32'd1539812500 &&
      descramblerSeed === 16'd23560 && syncWordErrorThreshold === 8'h04 &&
      freqSearchWindow === 16'd2200 && {serviceFilterEnable, descramblerEnable} === 2'b11 &&
      prescramblingEnable === 1'b0, "defaults");
    check(serialBaud === 32'd9600 && rxState === ST_BOOT, "port default");
    flashValid <= 1'b1;
    flashKey <= `CRXPC_K_SVCID;
    flashValue <= 64'h1234;
    @(posedge clk_sys);
    flashValid <= 1'b0;
    flashDone <= 1'b1;
    repeat (5) @(posedge clk_sys);
    check(serviceIdentifier === 16'h1234, "flash overlay");
    check(cnt[4] === 16'h1111 && rxState === ST_ACQ, "boot text once");
    $display("t_boot done");
  endtask : t_boot
  task automatic t_config;
    logic [31:0] r;
    logic e;
    cmd(`CRXPC_OP_SET, `CRXPC_K_FREQ, 64'd1525000000, 1'b1);
    cmd(`CRXPC_OP_SET, `CRXPC_K_FREQ, 64'd1559000001, 1'b0);
    check(channelCentreFreq === 32'd1525000000, "freq kept");
    cmd(`CRXPC_OP_SET, `CRXPC_K_RATE, 64'd4800, 1'b1);
    cmd(`CRXPC_OP_SET, `CRXPC_K_RATE, 64'd599, 1'b0);
    cmd(`CRXPC_OP_GET, `CRXPC_K_RATE, 64'h0, 1'b1);
    rd(`CRXPC_A_RD_LO, r, e);
    check(r === 32'd4800 && channelBitRate === 16'd4800, "get value");
    cmd(`CRXPC_OP_DEL, `CRXPC_K_FREQ, 64'h0, 1'b1);
    check(channelCentreFreq === 32'd1539812500, "delete restores");
    cmd(`CRXPC_OP_GET, 8'h7f, 64'h0, 1'b0);
    rd(`CRXPC_A_RESP, r, e);
    check(r[0] === 1'b0, "single response");
    rd(8'h40, r, e);
    check(e === 1'b1 && r === 32'h0, "unmapped read");
    $display("t_config done");
  endtask : t_config
  task automatic t_output;
    clrCnt <= 1'b1;
    @(posedge clk_sys);
    clrCnt <= 1'b0;
    cmd(`CRXPC_OP_SET, 8'h15, 64'd3, 1'b1);
    repeat (6) begin
      periodicEvent <= 1'b1;
      @(posedge clk_sys);
      periodicEvent <= 1'b0;
      @(posedge clk_sys);
    end
    frameServiceId <= 16'h1234;
    frameRx <= 1'b1;
    infoRequest <= 1'b1;
    @(posedge clk_sys);
    frameServiceId <= 16'h1235;
    infoRequest <= 1'b0;
    @(posedge clk_sys);
    frameRx <= 1'b0;
    cmd(`CRXPC_OP_SET, 8'h1a, 64'd1, 1'b1);
    cmd(`CRXPC_OP_SET, 8'h10, 64'd0, 1'b1);
    frameServiceId <= 16'h1234;
    frameRx <= 1'b1;
    infoRequest <= 1'b1;
    @(posedge clk_sys);
    frameRx <= 1'b0;
    infoRequest <= 1'b0;
    wr(`CRXPC_A_CMD, 32'h0003_0005);
    wr(`CRXPC_A_CMD, 32'h0000_0005);
    repeat (4) @(posedge clk_sys);
    check(cnt[0] === 16'h0020, "periodic every third");
    check(cnt[1] === 16'h2221, "frames filtered and gated");
    check(cnt[2] === 16'h1000 && cnt[3] === 16'h0100, "poll and info");
    $display("t_output done");
  endtask : t_output
  task automatic t_power;
    wr(`CRXPC_A_VAL_LO, 32'd2);
    wr(`CRXPC_A_CMD, {29'h0, `CRXPC_OP_PMREQ});
    repeat (2 * MS - 6) @(posedge clk_sys);
    check(rxState === ST_INACTIVE, "inactive for duration");
    repeat (12) @(posedge clk_sys);
    check(rxState === ST_ACQ, "duration ends");
    // Wake from an open-ended backup by each pin in turn
    for (int p = 0; p < 3; p++) begin
      wr(`CRXPC_A_VAL_LO, 32'd0);
      wr(`CRXPC_A_CMD, {29'h0, `CRXPC_OP_PMREQ});
      hostU.toggle(p);
      if (p == 2) begin
        check(rxState === ST_INACTIVE, "reset pin fall ignored");
        hostU.toggle(p);
      end
      check(rxState === ST_ACQ, "pin woke receiver");
    end
    hostU.toggle(0);
    lockAcquired <= 1'b1;
    hostU.toggle(1);
    check(rxState === ST_TRACK, "edges ignored while active");
    $display("t_power done");
  endtask : t_power
  task automatic end_sim;
    $display("comparisons %0d fail_count %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : end_sim
  initial begin
    {srst, clrCnt} = 2'b11;
    {flashValid, flashDone, periodicEvent, infoRequest, frameRx, lockAcquired} = '0;
    flashKey = '0;
    flashValue = '0;
    frameServiceId = '0;
    {fail_count, comparisons, expSeq} = '0;
    repeat (8) @(posedge clk_sys);
    srst <= 1'b0;
    clrCnt <= 1'b0;
    @(posedge clk_sys);
    t_boot;
    t_config;
    t_output;
    t_power;
    end_sim;
  end
  // Whole run needs about 340 cycles
  initial begin
    #40000;
    fail_count++;
    $display("[FAIL] %0t watchdog expired", $time);
    end_sim;
  end
endmodule : crxpc_top_tb
`default_nettype wire
